// ===== logic/ops_params.svh
// constants of the optical power set-point register bank
`ifndef OPS_PARAMS_SVH
`define OPS_PARAMS_SVH
// register numbers
`define OPS_ADDR_PEND 8'h00
`define OPS_ADDR_CHAN 8'h30
`define OPS_ADDR_PWR 8'h31
`define OPS_ADDR_RESET_AND_OUTPUT_CONTROL 8'h32
// response status codes
`define OPS_ST_OK 8'h00
`define OPS_ST_XE 8'h01
`define OPS_ST_CP 8'h03
// error field codes
`define OPS_ERR_OK 4'h0
`define OPS_ERR_RNW 4'h1
`define OPS_ERR_RVE 4'h2
`define OPS_ERR_CIP 4'h4
`define OPS_ERR_EXF 4'h8
`define OPS_ERR_CIE 4'h9
// field positions
`define OPS_PEND_BIT 8
`define OPS_RE_HARD 0
`define OPS_RE_SOFT 1
`define OPS_RE_SOFTWARE_OUTPUT_ENABLE 3
// reset values
`define OPS_RESET_AND_OUTPUT_CONTROL_RST 16'h0000
`define OPS_CHAN_RST 16'h0000
`define OPS_PWR_RST 16'h03e8
// timing: ramp step interval in ns, cycles at 8 ns
`define OPS_RAMP_STEP_NS 1000
`define OPS_CLK_NS 8
`define OPS_RAMP_STEP_CYC (`OPS_RAMP_STEP_NS / `OPS_CLK_NS)
`endif

// ===== logic/ops_pkg.sv
// types of the optical power set-point register bank
package ops_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] data;
  } ops_cmd_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] addr;
    logic [15:0] data;
  } ops_rsp_t;
  typedef enum logic [0:0] {PS_IDLE, PS_BUSY} ops_pend_state_t;
endpackage : ops_pkg

// ===== logic/ops_power_ramp.sv
// output power ramp: steps the drive toward the set point in bounded increments
`timescale 1ns/1ns
`default_nettype none
`include "ops_params.svh"
module ops_power_ramp #(
  parameter int STEP = 50,
  parameter int STEP_CYC = `OPS_RAMP_STEP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic signed [15:0] target_i,
  output logic signed [15:0] power_o,
  output logic busy_o
);
  import ops_pkg::*;
  generate
    if (STEP < 1 || STEP > 16'h7fff || STEP_CYC < 1 || STEP_CYC > 16'hffff) begin : g_bad
      $error("ops_power_ramp: step or interval out of range");
    end
  endgenerate
  logic signed [15:0] pwr_q, pwr_d;
  logic [15:0] cnt_q, cnt_d;
  logic signed [16:0] diff;
  // next drive value: move at most STEP per interval
  always_comb begin
    diff = 17'(target_i) - 17'(pwr_q);
    pwr_d = pwr_q;
    cnt_d = cnt_q;
    if (load_i) begin
      pwr_d = target_i;
      cnt_d = '0;
    end else if (diff != '0) begin
      if (cnt_q == 16'(STEP_CYC - 1)) begin
        cnt_d = '0;
        if (diff > 17'(STEP)) pwr_d = 16'(17'(pwr_q) + 17'(STEP));
        else if (diff < -17'(STEP)) pwr_d = 16'(17'(pwr_q) - 17'(STEP));
        else pwr_d = target_i;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end
  // drive registers
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pwr_q <= 16'(`OPS_PWR_RST);
      cnt_q <= '0;
    end else begin
      pwr_q <= pwr_d;
      cnt_q <= cnt_d;
    end
  end
  assign power_o = pwr_q;
  assign busy_o = (pwr_q != target_i);
  property p_ramp_step;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !load_i |=> ($signed(17'(power_o) - 17'($past(power_o))) <= 17'(STEP)) &&
                ($signed(17'(power_o) - 17'($past(power_o))) >= -17'(STEP));
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step too large");
endmodule : ops_power_ramp
`default_nettype wire

// ===== logic/ops_power_regs.sv
// optical power set-point, reset/enable and pending-status register bank
// What this block does
// - service request line goes low when a pending operation fails, by default
// - a tune-starting write answers command-pending with the pending bit in data
// - a failed pending operation clears its bit and sets error field to 0x8
// - power set point at 0x31 is signed 16-bit, hundredths of a dBm
// - power write answers before the output reaches the new level
// - good power write echoes and updates; good read returns value, no effect
// - failed power access answers execution error, data zero, error field set
// - set point resets to a default, replaced by a stored non-volatile value
// - in-lock power change moves output within limits, never interrupting traffic
// - out-of-range power write is rejected with execution error
// - in-range power needing a traffic interruption is refused with that code
// - traffic interruption means loss of lock; in-lock power variation is fine
// - large old-to-new power change may raise the power warning alarm
// - write to 0x32 starts soft or hard reset, or gates the output
// - bit0 hard reset, bit1 soft reset, bit3 output enable; hard wins
// - output on only if pin high, enable set and no gated fatal condition
`timescale 1ns/1ns
`default_nettype none
`include "ops_params.svh"
module ops_power_regs #(
  parameter logic signed [15:0] PWR_DEFAULT = 16'(`OPS_PWR_RST),
  parameter logic signed [15:0] PWR_MIN = 16'h0000,
  parameter logic signed [15:0] PWR_MAX = 16'h07d0,
  parameter int LOCK_STEP_MAX = 300,
  parameter int WARN_THRESH = 200,
  parameter int RAMP_STEP = 50,
  parameter int RAMP_STEP_CYC = `OPS_RAMP_STEP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire ops_pkg::ops_cmd_t cmd_i,
  output logic rsp_valid_o,
  output var ops_pkg::ops_rsp_t rsp_o,
  input wire logic chan_locked_i,
  output logic tune_req_o,
  output logic [15:0] tune_chan_o,
  input wire logic tune_done_i,
  input wire logic tune_fail_i,
  input wire logic srq_on_fail_i,
  input wire logic nv_pwr_valid_i,
  input wire logic signed [15:0] nv_pwr_i,
  input wire logic pin_output_inhibit_n_i,
  input wire logic fatal_active_i,
  input wire logic shutdown_on_fatal_i,
  output logic service_request_line_n_o,
  output logic optical_output_en_o,
  output logic hard_reset_o,
  output logic soft_reset_o,
  output logic signed [15:0] power_drive_o,
  output logic power_warning_alarm_o
);
  import ops_pkg::*;
  generate
    if (PWR_MIN > PWR_MAX || LOCK_STEP_MAX < 1 || WARN_THRESH < 0) begin : g_bad
      $error("ops_power_regs: bad power limits");
    end
  endgenerate

  // absolute difference of two signed set points
  function automatic logic [16:0] abs_diff(logic signed [15:0] a, logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    return d[16] ? 17'(-d) : 17'(d);
  endfunction : abs_diff

  ops_pend_state_t pend_q, pend_d;
  logic signed [15:0] pwr_q, pwr_d;
  logic [15:0] chan_q, chan_d;
  logic [3:0] err_q, err_d;
  logic software_output_enable_q, software_output_enable_d, srq_q, srq_d, warn_q, warn_d, init_q, init_d;
  logic hard_q, hard_d, soft_q, soft_d, treq_q, treq_d, rv_q, rv_d;
  ops_rsp_t rsp_q, rsp_d;
  logic pin_s1_q, pin_s2_q;
  logic ramp_busy;
  logic wr, rd;
  logic signed [15:0] wdat;

  assign wr = cmd_valid_i & cmd_i.wr;
  assign rd = cmd_valid_i & ~cmd_i.wr;
  assign wdat = cmd_i.data;

  // output-inhibit pin synchroniser
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_output_inhibit_n_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // command decode, pending tracking and control bits
  always_comb begin
    pend_d = pend_q;
    pwr_d = pwr_q;
    chan_d = chan_q;
    err_d = err_q;
    software_output_enable_d = software_output_enable_q;
    srq_d = srq_q;
    warn_d = warn_q;
    init_d = 1'b0;
    hard_d = 1'b0;
    soft_d = 1'b0;
    treq_d = 1'b0;
    rv_d = cmd_valid_i;
    rsp_d = '{status: `OPS_ST_OK, addr: cmd_i.addr, data: 16'h0000};
    // load set point after reset: stored value over built-in default
    if (init_q) pwr_d = nv_pwr_valid_i ? nv_pwr_i : PWR_DEFAULT;
    // reset actions requested one cycle earlier, after their answer
    if (soft_q) err_d = `OPS_ERR_OK;
    if (hard_q) begin
      init_d = 1'b1;
      software_output_enable_d = 1'b0;
      err_d = `OPS_ERR_OK;
      pend_d = PS_IDLE;
      srq_d = 1'b0;
    end
    if (warn_q && !ramp_busy) warn_d = 1'b0;
    unique case (cmd_i.addr)
      `OPS_ADDR_PEND: begin
        if (wr) begin
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_RNW;
        end else if (rd) begin
          rsp_d.data = {7'h00, pend_q == PS_BUSY, 4'h0, err_q};
          srq_d = 1'b0;
        end
      end
      `OPS_ADDR_CHAN: begin
        if (wr && pend_q == PS_BUSY) begin
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_CIP;
        end else if (wr && cmd_i.data == 16'h0000) begin
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_RVE;
        end else if (wr) begin
          chan_d = cmd_i.data;
          treq_d = 1'b1;
          pend_d = PS_BUSY;
          rsp_d.status = `OPS_ST_CP;
          rsp_d.data = 16'h0001 << `OPS_PEND_BIT;
        end else begin
          rsp_d.data = chan_q;
        end
      end
      `OPS_ADDR_PWR: begin
        if (wr && pend_q == PS_BUSY) begin
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_CIP;
        end else if (wr && (wdat < PWR_MIN || wdat > PWR_MAX)) begin
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_RVE;
        end else if (wr && chan_locked_i &&
                     abs_diff(wdat, power_drive_o) > 17'(LOCK_STEP_MAX)) begin
          // a step this large would unlock the channel
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_CIE;
        end else if (wr) begin
          pwr_d = wdat;
          rsp_d.data = cmd_i.data;
          if (abs_diff(wdat, pwr_q) > 17'(WARN_THRESH)) warn_d = 1'b1;
        end else begin
          rsp_d.data = pwr_q;
        end
      end
      `OPS_ADDR_RESET_AND_OUTPUT_CONTROL: begin
        if (wr) begin
          hard_d = cmd_i.data[`OPS_RE_HARD];
          soft_d = cmd_i.data[`OPS_RE_SOFT] & ~cmd_i.data[`OPS_RE_HARD];
          software_output_enable_d = cmd_i.data[`OPS_RE_SOFTWARE_OUTPUT_ENABLE];
          rsp_d.data = cmd_i.data;
        end else begin
          rsp_d.data = 16'(software_output_enable_q) << `OPS_RE_SOFTWARE_OUTPUT_ENABLE;
        end
      end
      default: begin
        if (cmd_valid_i) begin
          rsp_d.status = `OPS_ST_XE;
          err_d = `OPS_ERR_RVE;
        end
      end
    endcase
    if (!cmd_valid_i) rsp_d = '0;
    // pending operation end; a failure wins over a same-cycle soft reset or status read, but not over a hard reset
    if (pend_q == PS_BUSY && !hard_q && (tune_done_i || tune_fail_i)) begin
      pend_d = PS_IDLE;
      if (tune_fail_i) begin
        err_d = `OPS_ERR_EXF;
        if (srq_on_fail_i) srq_d = 1'b1;
      end
    end
    // low pin latches the software enable off
    if (!pin_s2_q) software_output_enable_d = 1'b0;
  end

  // register update
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pend_q <= PS_IDLE;
      pwr_q <= PWR_DEFAULT;
      chan_q <= `OPS_CHAN_RST;
      err_q <= `OPS_ERR_OK;
      software_output_enable_q <= 1'(`OPS_RESET_AND_OUTPUT_CONTROL_RST >> `OPS_RE_SOFTWARE_OUTPUT_ENABLE);
      srq_q <= 1'b0;
      warn_q <= 1'b0;
      init_q <= 1'b1;
      hard_q <= 1'b0;
      soft_q <= 1'b0;
      treq_q <= 1'b0;
      rv_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      pend_q <= pend_d;
      pwr_q <= pwr_d;
      chan_q <= chan_d;
      err_q <= err_d;
      software_output_enable_q <= software_output_enable_d;
      srq_q <= srq_d;
      warn_q <= warn_d;
      init_q <= init_d;
      hard_q <= hard_d;
      soft_q <= soft_d;
      treq_q <= treq_d;
      rv_q <= rv_d;
      rsp_q <= rsp_d;
    end
  end

  // output power follows the set point gradually
  ops_power_ramp #(.STEP(RAMP_STEP), .STEP_CYC(RAMP_STEP_CYC)) u_ramp (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(init_q),
    .target_i(pwr_q),
    .power_o(power_drive_o),
    .busy_o(ramp_busy)
  );

  // outputs
  assign rsp_valid_o = rv_q;
  assign rsp_o = rsp_q;
  assign tune_req_o = treq_q;
  assign tune_chan_o = chan_q;
  assign hard_reset_o = hard_q;
  assign soft_reset_o = soft_q;
  assign service_request_line_n_o = ~srq_q;
  assign power_warning_alarm_o = warn_q;
  assign optical_output_en_o = pin_s2_q & software_output_enable_q & ~(fatal_active_i & shutdown_on_fatal_i);

  property p_rsp_next;
    @(posedge sys_clk_i) disable iff (sys_rst_i) cmd_valid_i |=> rsp_valid_o;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no answer next cycle");
  property p_xe_zero;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rsp_valid_o && rsp_o.status == `OPS_ST_XE |-> rsp_o.data == 16'h0000 && err_q != 4'h0;
  endproperty
  a_xe_zero: assert property (p_xe_zero) else $error("error answer carries data");
  property p_tune_cp;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr && cmd_i.addr == `OPS_ADDR_CHAN && pend_q == PS_IDLE && cmd_i.data != 16'h0000 && !hard_q
    |=> rsp_o.status == `OPS_ST_CP && rsp_o.data == 16'h0100 && tune_req_o;
  endproperty
  a_tune_cp: assert property (p_tune_cp) else $error("tune not answered pending");
  property p_fail;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    pend_q == PS_BUSY && tune_fail_i && !hard_q |=> pend_q == PS_IDLE && err_q == 4'h8;
  endproperty
  a_fail: assert property (p_fail) else $error("failure not reported");
  property p_srq;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    pend_q == PS_BUSY && tune_fail_i && srq_on_fail_i && !hard_q |=> !service_request_line_n_o;
  endproperty
  a_srq: assert property (p_srq) else $error("service request not raised");
  property p_reject_keep;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr && cmd_i.addr == `OPS_ADDR_PWR && !init_q ##1 rsp_o.status == `OPS_ST_XE
    |-> pwr_q == $past(pwr_q);
  endproperty
  a_reject_keep: assert property (p_reject_keep) else $error("rejected write changed set point");
  property p_range;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr && cmd_i.addr == `OPS_ADDR_PWR && (wdat > PWR_MAX || wdat < PWR_MIN)
    |=> rsp_o.status == `OPS_ST_XE;
  endproperty
  a_range: assert property (p_range) else $error("out-of-range power accepted");
  property p_hard_wins;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    wr && cmd_i.addr == `OPS_ADDR_RESET_AND_OUTPUT_CONTROL && cmd_i.data[1:0] == 2'b11 |=> hard_reset_o && !soft_reset_o;
  endproperty
  a_hard_wins: assert property (p_hard_wins) else $error("soft reset beat hard reset");
  property p_out_en;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    optical_output_en_o |-> software_output_enable_q && pin_s2_q && !(fatal_active_i && shutdown_on_fatal_i);
  endproperty
  a_out_en: assert property (p_out_en) else $error("output on while disabled");
  property p_pend_rd;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd && cmd_i.addr == `OPS_ADDR_PEND && pend_q == PS_BUSY |=> rsp_o.data[8];
  endproperty
  a_pend_rd: assert property (p_pend_rd) else $error("pending bit lost");
  property p_pwr_rd;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    rd && cmd_i.addr == `OPS_ADDR_PWR |=> rsp_o.status == `OPS_ST_OK && rsp_o.data == pwr_q;
  endproperty
  a_pwr_rd: assert property (p_pwr_rd) else $error("set point read wrong");
  c_tune_fail: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    pend_q == PS_BUSY && tune_fail_i);
  c_cie: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rsp_valid_o && rsp_o.status == `OPS_ST_XE && err_q == `OPS_ERR_CIE);
  c_warn: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    power_warning_alarm_o ##1 !power_warning_alarm_o);
endmodule : ops_power_regs
`default_nettype wire

// ===== sim/ops_tune_model.sv
// tune engine model: answers a tune request with done or fail after a delay
`timescale 1ns/1ns
`default_nettype none
module ops_tune_model (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tune_req_i,
  input wire logic fail_mode_i,
  input wire logic [7:0] delay_i,
  output logic tune_done_o,
  output logic tune_fail_o
);
  logic [7:0] cnt_q;
  // countdown from request, one-cycle ending pulse
  always @(posedge sys_clk_i) begin
    tune_done_o <= 1'b0;
    tune_fail_o <= 1'b0;
    if (sys_rst_i) begin
      cnt_q <= 8'h00;
    end else if (tune_req_i) begin
      cnt_q <= delay_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        tune_fail_o <= fail_mode_i;
        tune_done_o <= !fail_mode_i;
      end
    end
  end
endmodule : ops_tune_model
`default_nettype wire

// ===== sim/ops_power_regs_tb.sv
// self-checking bench of the power set-point register bank
`timescale 1ns/1ns
`default_nettype none
`include "ops_params.svh"
module ops_power_regs_tb;
  import ops_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [15:0] d;
    logic [31:0] r;
  } ops_row_t;
  localparam logic [7:0] PW = `OPS_ADDR_PWR;
  localparam logic [7:0] RE = `OPS_ADDR_RESET_AND_OUTPUT_CONTROL;
  localparam logic [7:0] CH = `OPS_ADDR_CHAN;
  localparam logic [7:0] PD = `OPS_ADDR_PEND;
  localparam logic [7:0] OK = `OPS_ST_OK;
  localparam logic [7:0] XE = `OPS_ST_XE;
  localparam logic [15:0] PB = 16'h0001 << `OPS_PEND_BIT;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv = 1'b0;
  ops_cmd_t cmd = '0;
  logic locked = 1'b1;
  logic nvv = 1'b0;
  logic pin_n = 1'b1;
  logic fatal = 1'b0;
  logic sdf = 1'b1;
  logic fmode = 1'b1;
  logic rv, treq, tdone, tfail, srq_n, oen, hr, sr, warn;
  logic rv_q, hr_q, sr_q, tr_q;
  ops_rsp_t rsp, rsp_q;
  logic [15:0] tchan;
  logic signed [15:0] drv, dq, prev;
  ops_row_t rows [16];
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  ops_power_regs #(.RAMP_STEP_CYC(2)) dut (.sys_clk_i(clk), .sys_rst_i(rst),
    .cmd_valid_i(cv), .cmd_i(cmd), .rsp_valid_o(rv), .rsp_o(rsp),
    .chan_locked_i(locked), .tune_req_o(treq), .tune_chan_o(tchan),
    .tune_done_i(tdone), .tune_fail_i(tfail), .srq_on_fail_i(1'b1),
    .nv_pwr_valid_i(nvv), .nv_pwr_i(16'sh0123), .pin_output_inhibit_n_i(pin_n),
    .fatal_active_i(fatal), .shutdown_on_fatal_i(sdf),
    .service_request_line_n_o(srq_n), .optical_output_en_o(oen),
    .hard_reset_o(hr), .soft_reset_o(sr), .power_drive_o(drv),
    .power_warning_alarm_o(warn));
  ops_tune_model tm (.sys_clk_i(clk), .sys_rst_i(rst), .tune_req_i(treq),
    .fail_mode_i(fmode), .delay_i(8'h08), .tune_done_o(tdone), .tune_fail_o(tfail));
  // clock and cycle ceiling
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one command, answer captured in the cycle after the taking edge
  task automatic send(input logic w, input logic [7:0] a, input logic [15:0] d);
    cv = 1'b1;
    cmd = '{wr: w, addr: a, data: d};
    @(negedge clk);
    {rv_q, rsp_q, hr_q, sr_q, tr_q, dq} = {rv, rsp, hr, sr, treq, drv};
    cv = 1'b0;
    @(negedge clk);
  endtask : send
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  function automatic ops_row_t row(logic w, logic [7:0] a, logic [15:0] d,
      logic [7:0] st, logic [15:0] e);
    return {w, a, d, st, a, e};
  endfunction : row
  initial begin
    rows[0] = row(0, PW, 0, OK, `OPS_PWR_RST);
    rows[1] = row(1, PW, 16'h0400, OK, 16'h0400);
    rows[2] = row(0, PW, 0, OK, 16'h0400);
    rows[3] = row(1, PW, 16'h07d1, XE, 0);
    rows[4] = row(0, PD, 0, OK, {12'h0, `OPS_ERR_RVE});
    rows[5] = row(1, PW, 16'hffff, XE, 0);
    rows[6] = row(1, PW, 16'h07d0, XE, 0);
    rows[7] = row(0, PD, 0, OK, {12'h0, `OPS_ERR_CIE});
    rows[8] = row(0, PW, 0, OK, 16'h0400);
    rows[9] = row(1, PD, 16'h0001, XE, 0);
    rows[10] = row(0, PD, 0, OK, {12'h0, `OPS_ERR_RNW});
    rows[11] = row(0, 8'h77, 0, XE, 0);
    rows[12] = row(1, CH, 0, XE, 0);
    rows[13] = row(0, PD, 0, OK, {12'h0, `OPS_ERR_RVE});
    rows[14] = row(1, RE, 16'h0008, OK, 16'h0008);
    rows[15] = row(0, RE, 0, OK, 16'h0008);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk({rsp, srq_n, oen, drv, warn}, {32'h0, 1'b1, 1'b0, 16'h03e8, 1'b0});
    repeat (2) @(negedge clk);
    $display("reset test done");
    // table of plain accesses
    foreach (rows[i]) begin
      send(rows[i].wr, rows[i].a, rows[i].d);
      chk({rv_q, rsp_q}, {1'b1, rows[i].r});
    end
    chk(drv, 16'h0400);
    $display("table test done");
    // output gating by pin, enable and fatal
    chk(oen, 1);
    fatal = 1'b1;
    @(negedge clk);
    chk(oen, 0);
    sdf = 1'b0;
    @(negedge clk);
    chk(oen, 1);
    fatal = 1'b0;
    pin_n = 1'b0;
    repeat (4) @(negedge clk);
    chk(oen, 0);
    pin_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(oen, 0);
    send(0, RE, 0);
    chk(rsp_q, {OK, RE, 16'h0000});
    $display("output test done");
    // soft reset alone clears the error field
    send(1, PW, 16'h0900);
    send(1, RE, 16'h0002);
    chk({rsp_q, hr_q, sr_q}, {OK, RE, 16'h0002, 2'b01});
    send(0, PD, 0);
    chk(rsp_q, {OK, PD, 16'h0000});
    $display("soft reset test done");
    // large unlocked step: accepted, ramped, warned
    locked = 1'b0;
    send(1, PW, 16'h0600);
    chk({rsp_q, dq, warn}, {OK, PW, 16'h0600, 16'h0400, 1'b1});
    prev = drv;
    for (int n = 0; n < 100 && drv !== 16'sh0600; n++) begin
      @(negedge clk);
      if (drv - prev > 50 || prev - drv > 50) chk(drv, prev);
      prev = drv;
    end
    chk(drv, 16'h0600);
    repeat (2) @(negedge clk);
    chk(warn, 0);
    locked = 1'b1;
    $display("ramp test done");
    // failing tune: pending, refusal, service request
    send(1, CH, 16'h0001);
    chk({rsp_q, tr_q}, {`OPS_ST_CP, CH, PB, 1'b1});
    chk(tchan, 16'h0001);
    send(0, PD, 0);
    chk(rsp_q, {OK, PD, PB});
    send(1, PW, 16'h0500);
    chk(rsp_q, {XE, PW, 16'h0000});
    for (int n = 0; n < 40 && srq_n !== 1'b0; n++) @(negedge clk);
    chk(srq_n, 0);
    send(0, PD, 0);
    chk(rsp_q, {OK, PD, 12'h0, `OPS_ERR_EXF});
    chk(srq_n, 1);
    $display("tune fail test done");
    // successful tune ends pending without a service request
    fmode = 1'b0;
    send(1, CH, 16'h0002);
    for (int n = 0; n < 40 && rsp_q.data[`OPS_PEND_BIT] !== 1'b0; n++) send(0, PD, 0);
    chk({rsp_q.data[`OPS_PEND_BIT], srq_n}, 2'b01);
    $display("tune done test done");
    // hard reset wins over soft and reloads stored set point
    nvv = 1'b1;
    send(1, RE, 16'h000b);
    chk({rsp_q, hr_q, sr_q}, {OK, RE, 16'h000b, 2'b10});
    repeat (3) @(negedge clk);
    send(0, PW, 0);
    chk(rsp_q, {OK, PW, 16'h0123});
    send(0, RE, 0);
    chk(rsp_q, {OK, RE, 16'h0000});
    $display("hard reset test done");
    close_out();
  end
endmodule : ops_power_regs_tb
`default_nettype wire
